// ===== ssw_pkg.sv
// Purpose: shared constants and types for the supply supervisor watchdog
// Assumes: 125 MHz internal oscillator clock
// Notes:   times kept in their printed units, cycle counts derived here
package ssw_pkg;
  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned PULSE_MS       = 200;
  localparam int unsigned EXTEND_MS      = 100;
  localparam int unsigned WDOG_MS        = 1600;
  localparam int unsigned MIN_KICK_NS    = 50;
  localparam int unsigned CNT_W          = 28;
  localparam longint unsigned PULSE_CYC  =
    longint'(CLK_HZ) * PULSE_MS / 1000;
  localparam longint unsigned EXTEND_CYC =
    longint'(CLK_HZ) * EXTEND_MS / 1000;
  localparam longint unsigned WDOG_CYC   =
    longint'(CLK_HZ) * WDOG_MS / 1000;
  localparam longint unsigned MIN_KICK_CYC =
    (longint'(CLK_HZ) * MIN_KICK_NS + 64'd999_999_999) / 64'd1_000_000_000;

  typedef struct packed {
    logic supply_ok;
    logic kick_float;
    logic kick_level;
    logic manual_reset_n;
  } ssw_in_t;

  typedef enum logic [1:0] {
    SSW_LOW   = 2'b00,
    SSW_PULSE = 2'b01,
    SSW_RUN   = 2'b10
  } ssw_state_t;
endpackage

// ===== ssw_supervisor.sv
// Purpose: reset generator with supply monitor, watchdog and manual reset
// Assumes: inputs already synchronous to mclk_i; supply flag from comparator
// Notes:   reset_n_o low means reset asserted
`timescale 1ns/1ps
`default_nettype none
module ssw_supervisor
  import ssw_pkg::*;
#(
  parameter logic [CNT_W-1:0] PULSE_CYCLES  = CNT_W'(PULSE_CYC),
  parameter logic [CNT_W-1:0] EXTEND_CYCLES = CNT_W'(EXTEND_CYC),
  parameter logic [CNT_W-1:0] WDOG_CYCLES   = CNT_W'(WDOG_CYC)
) (
  // clock and reset
  input  wire logic            mclk_i,
  input  wire logic            rstn_i,
  // supply and pin flags
  input  wire ssw_pkg::ssw_in_t pins_i,
  // reset output and status
  output logic                 reset_n_o,
  output logic                 wdog_timeout_o
);
  import ssw_pkg::*;

  // pulse length for any trigger, never shorter than the extension
  function automatic logic [CNT_W-1:0] pulse_load(
    input logic [CNT_W-1:0] full_len,
    input logic [CNT_W-1:0] ext_len
  );
    logic [CNT_W-1:0] len;
    len = full_len;
    if (ext_len > full_len) begin
      len = ext_len;
    end
    return len;
  endfunction

  // last count of a down-counter
  function automatic logic cnt_done(
    input logic [CNT_W-1:0] cnt
  );
    return cnt <= CNT_W'(1);
  endfunction

  // watchdog limit reached
  function automatic logic wdog_limit(
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] limit
  );
    return cnt >= limit - 1'b1;
  endfunction

  // sequencer state
  ssw_state_t       state;
  ssw_state_t       next_state;
  logic [CNT_W-1:0] pulse_cnt;
  logic [CNT_W-1:0] next_pulse_cnt;
  logic [CNT_W-1:0] pulse_len;

  // watchdog state
  logic [CNT_W-1:0] wdog_cnt;
  logic [CNT_W-1:0] next_wdog_cnt;
  logic             kick_prev;

  // decoded conditions
  logic             kick_live;
  logic             kick_edge;
  logic             wdog_at_limit;
  logic             wdog_fire;
  logic             hold_low;
  logic             next_reset_n;
  logic             next_timeout;

  // a brownout restarts the whole interval, at least the extension
  assign pulse_len = pulse_load(PULSE_CYCLES, EXTEND_CYCLES);

  // driven kick input only; a floating pin never counts
  assign kick_live = !pins_i.kick_float;

  // one sample per 8 ns cycle, so a 50 ns kick spans several samples
  assign kick_edge = kick_live &&
                     (pins_i.kick_level != kick_prev);

  assign wdog_at_limit = wdog_limit(wdog_cnt, WDOG_CYCLES);
  assign wdog_fire = (state == SSW_RUN) && kick_live && !kick_edge &&
                     wdog_at_limit;

  // supply low or button held keeps the output low
  assign hold_low  = !pins_i.supply_ok || !pins_i.manual_reset_n;

  // previous kick level for edge detection
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      kick_prev <= 1'b0;
    end else begin
      kick_prev <= pins_i.kick_level;
    end
  end

  // sequencer: next state and pulse count
  always_comb begin
    next_state     = state;
    next_pulse_cnt = pulse_cnt;
    case (state)
      SSW_LOW: begin
        next_pulse_cnt = '0;
        if (!hold_low) begin
          next_state     = SSW_PULSE;
          next_pulse_cnt = pulse_len;
        end
      end
      SSW_PULSE: begin
        if (hold_low) begin
          next_state     = SSW_LOW;
          next_pulse_cnt = '0;
        end else if (cnt_done(pulse_cnt)) begin
          next_state     = SSW_RUN;
          next_pulse_cnt = '0;
        end else begin
          next_pulse_cnt = pulse_cnt - 1'b1;
        end
      end
      SSW_RUN: begin
        if (hold_low) begin
          next_state     = SSW_LOW;
          next_pulse_cnt = '0;
        end else if (wdog_fire) begin
          next_state     = SSW_PULSE;
          next_pulse_cnt = pulse_len;
        end
      end
      default: begin
        next_state     = SSW_LOW;
        next_pulse_cnt = '0;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= SSW_LOW;
    end else begin
      state <= next_state;
    end
  end

  // pulse interval counter, runs on the internal clock
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pulse_cnt <= '0;
    end else begin
      pulse_cnt <= next_pulse_cnt;
    end
  end

  // watchdog counter: next value
  always_comb begin
    next_wdog_cnt = wdog_cnt;
    if (state != SSW_RUN || hold_low) begin
      next_wdog_cnt = '0;
    end else if (!kick_live) begin
      next_wdog_cnt = '0;
    end else if (kick_edge) begin
      next_wdog_cnt = '0;
    end else if (wdog_fire) begin
      next_wdog_cnt = '0;
    end else begin
      next_wdog_cnt = wdog_cnt + 1'b1;
    end
  end

  // watchdog counter register
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wdog_cnt <= '0;
    end else begin
      wdog_cnt <= next_wdog_cnt;
    end
  end

  // output decode; the first RUN cycle still drives low
  always_comb begin
    next_reset_n = 1'b0;
    next_timeout = 1'b0;
    if ((state == SSW_RUN) && !hold_low) begin
      next_reset_n = !wdog_fire;
      next_timeout = wdog_fire;
    end
  end

  // reset output register
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reset_n_o <= 1'b0;
    end else begin
      reset_n_o <= next_reset_n;
    end
  end

  // timeout strobe register, high for one cycle per expiry
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wdog_timeout_o <= 1'b0;
    end else begin
      wdog_timeout_o <= next_timeout;
    end
  end
endmodule
`default_nettype wire

// ===== ssw_cpu_model.sv
// Purpose: processor side, kicks the watchdog; Assumes: mclk_i; Notes: none
`timescale 1ns/1ps
`default_nettype none
module ssw_cpu_model (
  input  wire logic mclk_i,
  input  wire logic run_i,
  input  wire logic reset_n_i,
  output logic      kick_o
);
  logic [3:0] n = 4'h0;
  initial kick_o = 1'b0;
  // toggle every 16 cycles, far above the minimum pulse width
  always @(posedge mclk_i) if (run_i && reset_n_i) begin
    n <= n + 4'h1;
    if (n == 4'h9) kick_o <= #1 !kick_o;
  end
endmodule
`default_nettype wire

// ===== ssw_supervisor_asserts.sv
// Purpose: checker; Assumes: short counts; Notes: bound after module
`timescale 1ns/1ps
`default_nettype none
module ssw_supervisor_asserts import ssw_pkg::*; #(
  parameter int PULSE_CYCLES = 20
) (
  input wire logic             mclk_i,
  input wire logic             rstn_i,
  input wire ssw_pkg::ssw_in_t pins_i,
  input wire logic             reset_n_o,
  input wire logic             wdog_timeout_o
);
  localparam int RB = PULSE_CYCLES + 4;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  wire h = !pins_i.supply_ok || !pins_i.manual_reset_n;
  property p_low; h |=> !reset_n_o; endproperty
  a_low: assert property (p_low) else $error("reset not low");
  property p_stay; h ##1 !h |-> !reset_n_o [*8]; endproperty
  a_stay: assert property (p_stay) else $error("pulse short");
  property p_rel; $fell(h) |-> ##[1:RB] (reset_n_o || h); endproperty
  a_rel: assert property (p_rel) else $error("no release");
  property p_to; wdog_timeout_o |-> ##[0:1] !reset_n_o; endproperty
  a_to: assert property (p_to) else $error("timeout no reset");
  property p_one; wdog_timeout_o |=> !wdog_timeout_o; endproperty
  a_one: assert property (p_one) else $error("timeout long");
  property p_flt; pins_i.kick_float [*2] |-> !wdog_timeout_o; endproperty
  a_flt: assert property (p_flt) else $error("float timeout");
  property p_rst; !reset_n_o [*2] |-> !wdog_timeout_o; endproperty
  a_rst: assert property (p_rst) else $error("timeout in reset");
  property p_kick;
    !pins_i.kick_float && $changed(pins_i.kick_level) |-> ##2 !wdog_timeout_o;
  endproperty
  a_kick: assert property (p_kick) else $error("kick ignored");
  c_to: cover property (wdog_timeout_o);
  c_fall: cover property (h ##1 !h);
  c_rel: cover property ($rose(reset_n_o));
endmodule
bind ssw_supervisor ssw_supervisor_asserts #(.PULSE_CYCLES(PULSE_CYCLES))
  u_chk (.mclk_i(mclk_i), .rstn_i(rstn_i), .pins_i(pins_i),
  .reset_n_o(reset_n_o), .wdog_timeout_o(wdog_timeout_o));
`default_nettype wire

// ===== supply_supervisor_watchdog_tb.sv
// Purpose: bench; Assumes: short counts; Notes: release cycles queued
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog_tb;
  import ssw_pkg::*;
  localparam int PC = 20;
  logic mclk_i, rstn_i, reset_n_o, wdog_timeout_o, run, kick, sup, flt, mrn;
  logic prv = 1'b0;
  ssw_in_t pins_i;
  int bad_count = 0, checks_done = 0, cyc = 0, seed = 48557, tos = 0;
  int q[$];
  assign pins_i = {sup, flt, kick, mrn};
  ssw_supervisor #(.PULSE_CYCLES(28'd20), .EXTEND_CYCLES(28'd10),
    .WDOG_CYCLES(28'd40)) u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .pins_i(pins_i), .reset_n_o(reset_n_o), .wdog_timeout_o(wdog_timeout_o));
  ssw_cpu_model u_cpu (.mclk_i(mclk_i), .run_i(run), .reset_n_i(reset_n_o),
    .kick_o(kick));
  initial begin mclk_i = 0; forever #4 mclk_i = ~mclk_i; end
  always @(posedge mclk_i) cyc <= cyc + 1;
  task automatic chk(input int e, input int g);
    checks_done++;
    if (e !== g) begin bad_count++; $display("BAD %0t %h %h", $time, e, g); end
  endtask
  task automatic results;
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic st(input int n); repeat (n) @(posedge mclk_i); #1; endtask
  function automatic int rn(); return $unsigned($random(seed)) % 6 + 1;
  endfunction
  // watcher: each release of reset is matched to the oldest note
  always @(posedge mclk_i) begin
    #1;
    if (reset_n_o === 1'b1 && prv !== 1'b1)
      chk(q.size() ? q.pop_front() : -1, cyc);
    if (wdog_timeout_o === 1'b1) tos++;
    prv = reset_n_o;
  end
  initial begin
    rstn_i = 0; sup = 0; flt = 1; mrn = 1; run = 0;
    st(5); rstn_i = 1;
    st(3); sup = 1;
    st(rn() + 3); sup = 0;
    st(rn()); sup = 1; q.push_back(cyc + PC + 2);
    st(PC + 5); mrn = 0;
    st(rn()); mrn = 1; q.push_back(cyc + PC + 2);
    st(PC + 5); flt = 0; run = 1;
    st(200); chk(0, tos);
    run = 0;
    repeat (100) if (tos == 0) st(1);
    sup = 0;
    st(rn()); sup = 1; q.push_back(cyc + PC + 2);
    st(PC + 5); chk(1, tos);
    flt = 1;
    st(150); chk(1, tos);
    chk(0, q.size());
    results;
  end
  initial begin #20000; bad_count++; results; end
endmodule
`default_nettype wire
